/* File: include/pcr_pkg.sv */
// pcr_pkg: offsets, field layouts and fixed values of the capability words
package pcr_pkg;

  // ==========================================================================
  // register offsets (byte addresses on the configuration port)
  localparam logic [7:0] PCR_CAP_HDR_OFS = 8'hB0;
  localparam logic [7:0] PCR_DEV_CAP_OFS = 8'hB4;

  // ==========================================================================
  // capability header word, fixed values and field positions
  localparam logic [7:0] PCR_CAP_ID = 8'h10;
  localparam logic [3:0] PCR_CAP_VER = 4'h1;
  localparam logic [3:0] PCR_TYPE_FWD = 4'h7;
  localparam logic [3:0] PCR_TYPE_REV = 4'h8;
  localparam logic [4:0] PCR_INT_MSG_NUM = 5'h00;
  localparam int PCR_HDR_ID_LSB = 0;
  localparam int PCR_HDR_NEXT_LSB = 8;
  localparam int PCR_HDR_VER_LSB = 16;
  localparam int PCR_HDR_TYPE_LSB = 20;
  localparam int PCR_HDR_SLOT_BIT = 24;

  // ==========================================================================
  // device capabilities word, fixed values and field positions
  localparam logic [2:0] PCR_MPS_CODE = 3'h1;
  localparam logic [1:0] PCR_PHANTOM = 2'h0;
  localparam logic PCR_TAG8 = 1'b1;
  localparam logic [2:0] PCR_L0S_LAT = 3'h0;
  localparam logic [2:0] PCR_L1_LAT = 3'h0;
  localparam int PCR_DEV_MPS_LSB = 0;
  localparam int PCR_DEV_PHANTOM_LSB = 3;
  localparam int PCR_DEV_TAG8_BIT = 5;
  localparam int PCR_DEV_L0S_LSB = 6;
  localparam int PCR_DEV_L1_LSB = 9;
  localparam int PCR_DEV_ATT_BTN_BIT = 12;
  localparam int PCR_DEV_ATT_IND_BIT = 13;
  localparam int PCR_DEV_PWR_IND_BIT = 14;
  localparam int PCR_DEV_SPL_VAL_LSB = 18;
  localparam int PCR_DEV_SPL_SCL_LSB = 26;

  // ==========================================================================
  // reset values
  localparam logic [7:0] PCR_SPL_VAL_RST = 8'h00;
  localparam logic [1:0] PCR_SPL_SCL_RST = 2'h0;
  localparam logic [31:0] PCR_RDATA_RST = 32'h0000_0000;

  // ==========================================================================
  // strap capture: cycles after reset release before straps are taken
  localparam logic [1:0] PCR_STRAP_SETTLE_CYC = 2'h2;

  // strap capture sequence
  typedef enum logic [1:0] {
    PCR_ST_SETTLE,
    PCR_ST_CAPTURE,
    PCR_ST_HOLD
  } pcr_strap_st_t;

endpackage

/* File: rtl/pcr_capability_regs.sv */
// pcr_capability_regs: read-only express capability words at B0h and B4h
`timescale 1ns/1ps
module pcr_capability_regs #(
  parameter logic [7:0] NEXT_PTR = 8'h00
) (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic BRIDGE_REVERSE_I,
  input wire logic HOTPLUG_EN_I,
  input wire logic SPL_MSG_VALID_I,
  input wire logic [7:0] SPL_MSG_VALUE_I,
  input wire logic [1:0] SPL_MSG_SCALE_I,
  output logic STRAPS_VALID_O
);
  import pcr_pkg::*;

  // ==========================================================================
  // elaboration checks
  if (NEXT_PTR[1:0] != 2'h0) begin : g_bad_ptr
    $error("next capability link must be dword aligned");
  end

  // ==========================================================================
  // decode helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================================
  // strap synchronisers and capture
  logic rev_meta;
  logic rev_sync;
  logic hp_meta;
  logic hp_sync;
  logic next_rev_meta;
  logic next_rev_sync;
  logic next_hp_meta;
  logic next_hp_sync;
  pcr_strap_st_t st;
  pcr_strap_st_t next_st;
  logic [1:0] settle_cnt;
  logic [1:0] next_settle_cnt;
  logic rev_mode;
  logic next_rev_mode;
  logic hp_fwd;
  logic next_hp_fwd;

  // two-stage sync of the strap pins, first stage feeds only the second
  always_comb begin
    next_rev_meta = BRIDGE_REVERSE_I;
    next_rev_sync = rev_meta;
    next_hp_meta = HOTPLUG_EN_I;
    next_hp_sync = hp_meta;
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rev_meta <= 1'b0;
      rev_sync <= 1'b0;
      hp_meta <= 1'b0;
      hp_sync <= 1'b0;
    end else begin
      rev_meta <= next_rev_meta;
      rev_sync <= next_rev_sync;
      hp_meta <= next_hp_meta;
      hp_sync <= next_hp_sync;
    end
  end

  // wait for the syncs to fill, take the straps once, then hold them
  always_comb begin
    next_st = st;
    next_settle_cnt = settle_cnt;
    next_rev_mode = rev_mode;
    next_hp_fwd = hp_fwd;
    unique case (st)
      PCR_ST_SETTLE: begin
        next_settle_cnt = settle_cnt + 2'h1;
        if (settle_cnt == PCR_STRAP_SETTLE_CYC - 2'h1) begin
          next_st = PCR_ST_CAPTURE;
        end
      end
      PCR_ST_CAPTURE: begin
        next_rev_mode = rev_sync;
        next_hp_fwd = hp_sync & ~rev_sync;
        next_st = PCR_ST_HOLD;
      end
      PCR_ST_HOLD: begin
        next_st = PCR_ST_HOLD;
      end
      default: begin
        next_st = PCR_ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st <= PCR_ST_SETTLE;
      settle_cnt <= 2'h0;
      rev_mode <= 1'b0;
      hp_fwd <= 1'b0;
    end else begin
      st <= next_st;
      settle_cnt <= next_settle_cnt;
      rev_mode <= next_rev_mode;
      hp_fwd <= next_hp_fwd;
    end
  end

  assign STRAPS_VALID_O = (st == PCR_ST_HOLD);

  // ==========================================================================
  // captured slot power limit
  logic [7:0] spl_value;
  logic [1:0] spl_scale;
  logic [7:0] next_spl_value;
  logic [1:0] next_spl_scale;

  // each received limit message loads value and scale together
  always_comb begin
    next_spl_value = spl_value;
    next_spl_scale = spl_scale;
    if (SPL_MSG_VALID_I) begin
      next_spl_value = SPL_MSG_VALUE_I;
      next_spl_scale = SPL_MSG_SCALE_I;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      spl_value <= PCR_SPL_VAL_RST;
      spl_scale <= PCR_SPL_SCL_RST;
    end else begin
      spl_value <= next_spl_value;
      spl_scale <= next_spl_scale;
    end
  end

  // ==========================================================================
  // word assembly and read port
  logic [31:0] hdr_word;
  logic [31:0] dev_word;
  logic [31:0] next_rdata;

  // header word, bits 31:30 reserved zero
  always_comb begin
    hdr_word = 32'h0000_0000;
    hdr_word[PCR_HDR_ID_LSB +: 8] = PCR_CAP_ID;
    hdr_word[PCR_HDR_NEXT_LSB +: 8] = NEXT_PTR;
    hdr_word[PCR_HDR_VER_LSB +: 4] = PCR_CAP_VER;
    hdr_word[PCR_HDR_TYPE_LSB +: 4] =
      rev_mode ? PCR_TYPE_REV : PCR_TYPE_FWD;
    hdr_word[PCR_HDR_SLOT_BIT] = rev_mode;
    hdr_word[29:25] = PCR_INT_MSG_NUM;
  end

  // device capabilities word, bits 17:15 and 31:28 reserved zero
  always_comb begin
    dev_word = 32'h0000_0000;
    dev_word[PCR_DEV_MPS_LSB +: 3] = PCR_MPS_CODE;
    dev_word[PCR_DEV_PHANTOM_LSB +: 2] = PCR_PHANTOM;
    dev_word[PCR_DEV_TAG8_BIT] = PCR_TAG8;
    dev_word[PCR_DEV_L0S_LSB +: 3] = PCR_L0S_LAT;
    dev_word[PCR_DEV_L1_LSB +: 3] = PCR_L1_LAT;
    dev_word[PCR_DEV_ATT_BTN_BIT] = hp_fwd;
    dev_word[PCR_DEV_ATT_IND_BIT] = hp_fwd;
    dev_word[PCR_DEV_PWR_IND_BIT] = hp_fwd;
    dev_word[PCR_DEV_SPL_VAL_LSB +: 8] = spl_value;
    dev_word[PCR_DEV_SPL_SCL_LSB +: 2] = spl_scale;
  end

  // read data stand only in the cycle after the strobe; writes are dropped
  always_comb begin
    next_rdata = PCR_RDATA_RST;
    if (RD_I) begin
      if (hit(ADDR_I, PCR_CAP_HDR_OFS)) begin
        next_rdata = hdr_word;
      end else if (hit(ADDR_I, PCR_DEV_CAP_OFS)) begin
        next_rdata = dev_word;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RDATA_O <= PCR_RDATA_RST;
    end else begin
      RDATA_O <= next_rdata;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  logic wr_unused;
  assign wr_unused = WR_I & (|WDATA_I);

  a_header_ident:
  assert property (RD_I && hit(ADDR_I, PCR_CAP_HDR_OFS) |=>
    RDATA_O[7:0] == 8'h10 && RDATA_O[19:16] == 4'h1)
  else $error("capability id or version wrong");

  a_port_type:
  assert property (RD_I && hit(ADDR_I, PCR_CAP_HDR_OFS) |=>
    RDATA_O[23:20] == ($past(rev_mode) ? 4'h8 : 4'h7))
  else $error("port type does not follow bridge mode");

  a_slot_bit:
  assert property (RD_I && hit(ADDR_I, PCR_CAP_HDR_OFS) |=>
    RDATA_O[24] == $past(rev_mode) && RDATA_O[31:25] == 7'h00)
  else $error("slot implemented bit wrong");

  a_dev_fixed:
  assert property (RD_I && hit(ADDR_I, PCR_DEV_CAP_OFS) |=>
    RDATA_O[11:0] == 12'h021 && RDATA_O[17:15] == 3'h0
    && RDATA_O[31:28] == 4'h0)
  else $error("fixed device capability fields wrong");

  a_hotplug_bits:
  assert property (st == PCR_ST_CAPTURE |=>
    rev_mode == $past(rev_sync)
    && hp_fwd == ($past(hp_sync) & ~$past(rev_sync)))
  else $error("straps not taken from the synchronised pins");

  a_hotplug_read:
  assert property (RD_I && hit(ADDR_I, PCR_DEV_CAP_OFS) |=>
    RDATA_O[14:12] == {3{$past(hp_fwd)}}
    && !(RDATA_O[12] && $past(rev_mode)))
  else $error("indicator bits do not follow hot-plug strap");

  a_limit_load:
  assert property (SPL_MSG_VALID_I ##1 !SPL_MSG_VALID_I && RD_I
    && hit(ADDR_I, PCR_DEV_CAP_OFS) |=>
    RDATA_O[27:18] == {$past(SPL_MSG_SCALE_I, 2), $past(SPL_MSG_VALUE_I, 2)})
  else $error("captured power limit not loaded");

  a_limit_reset:
  assert property ($rose(RSTN_I) |->
    spl_value == PCR_SPL_VAL_RST && spl_scale == PCR_SPL_SCL_RST)
  else $error("power limit not cleared by reset");

  a_unmapped_zero:
  assert property (RD_I && !hit(ADDR_I, PCR_CAP_HDR_OFS)
    && !hit(ADDR_I, PCR_DEV_CAP_OFS) |=> RDATA_O == 32'h0000_0000)
  else $error("unmapped read returned data");

  a_limit_hold:
  assert property (!SPL_MSG_VALID_I |=> $stable(spl_value)
    && $stable(spl_scale))
  else $error("power limit changed without a message");

  a_read_only:
  assert property (!RD_I |=> RDATA_O == 32'h0000_0000)
  else $error("read data outside the read cycle");

  a_strap_stable:
  assert property (st == PCR_ST_HOLD |=> st == PCR_ST_HOLD
    && $stable(rev_mode) && $stable(hp_fwd))
  else $error("straps changed after capture");

  a_strap_settle:
  assert property ($rose(RSTN_I) |-> ##[1:4] STRAPS_VALID_O)
  else $error("straps not captured in time");

  c_read_header:
  cover property (RD_I && hit(ADDR_I, PCR_CAP_HDR_OFS));

  c_read_devcap:
  cover property (RD_I && hit(ADDR_I, PCR_DEV_CAP_OFS));

  c_limit_msg:
  cover property (SPL_MSG_VALID_I ##1 RD_I
    && hit(ADDR_I, PCR_DEV_CAP_OFS));

  c_write_ignored:
  cover property (wr_unused ##1 RD_I && hit(ADDR_I, PCR_DEV_CAP_OFS));

  c_reverse_mode:
  cover property (st == PCR_ST_CAPTURE ##1 rev_mode && hp_sync);

endmodule

/* File: verification/test_pcr_capability_regs.sv */
// test_pcr_capability_regs: directed bench for the capability words
`timescale 1ns/1ps
module test_pcr_capability_regs;
  import pcr_pkg::*;
  // non-default link value so the parameter path is exercised
  localparam logic [7:0] NXT = 8'hC0;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rev = 1'b0;
  logic hp = 1'b0;
  logic spl_v = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] spl_val = 8'h00;
  logic [1:0] spl_scl = 2'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic straps_ok;
  int miscompares = 0;
  int total_checks = 0;

  // ==========================================================================
  // clock and device
  always #20 sys_clk = ~sys_clk;

  pcr_capability_regs #(.NEXT_PTR(NXT)) dut (
    .SYS_CLK_I(sys_clk), .RSTN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .BRIDGE_REVERSE_I(rev),
    .HOTPLUG_EN_I(hp), .SPL_MSG_VALID_I(spl_v), .SPL_MSG_VALUE_I(spl_val),
    .SPL_MSG_SCALE_I(spl_scl), .STRAPS_VALID_O(straps_ok)
  );

  // ==========================================================================
  // comparison, expected words and closing report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] hdr_exp(input logic r);
    return {2'h0, 5'h00, r, r ? 4'h8 : 4'h7, 4'h1, NXT, 8'h10};
  endfunction

  function automatic logic [31:0] dev_exp(input logic h, input logic r,
                                          input logic [7:0] v,
                                          input logic [1:0] s);
    return {4'h0, s, v, 3'h0, {3{h & ~r}}, 3'h0, 3'h0, 1'b1, 2'h0, 3'h1};
  endfunction

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================================
  // bus and message drivers
  task automatic do_reset(input logic r, input logic h);
    int n;
    n = 0;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    rev <= r;
    hp <= h;
    repeat (16) @(posedge sys_clk);
    chk({31'h0, straps_ok}, 32'h0);
    rst_n <= 1'b1;
    // straps must be captured within a few edges of release
    while (straps_ok !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk({31'h0, straps_ok}, 32'h1);
    chk(n, 32'h3);
    if (straps_ok !== 1'b1) begin
      summarize();
    end
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // two limit messages on consecutive edges; the second must win
  task automatic spl_pair(input logic [7:0] v1, input logic [1:0] s1,
                          input logic [7:0] v2, input logic [1:0] s2);
    @(posedge sys_clk);
    spl_v <= 1'b1;
    spl_val <= v1;
    spl_scl <= s1;
    @(posedge sys_clk);
    spl_val <= v2;
    spl_scl <= s2;
    @(posedge sys_clk);
    spl_v <= 1'b0;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_fixed_forward;
    logic [31:0] d;
    do_reset(1'b0, 1'b0);
    rd_reg(PCR_CAP_HDR_OFS, d);
    chk(d, hdr_exp(1'b0));
    rd_reg(PCR_DEV_CAP_OFS, d);
    chk(d, dev_exp(1'b0, 1'b0, 8'h00, 2'h0));
  endtask

  task automatic t_writes_ignored;
    logic [31:0] d;
    wr_reg(PCR_CAP_HDR_OFS, 32'hFFFF_FFFF);
    wr_reg(PCR_DEV_CAP_OFS, 32'hFFFF_FFFF);
    rd_reg(PCR_CAP_HDR_OFS, d);
    chk(d, hdr_exp(1'b0));
    rd_reg(PCR_DEV_CAP_OFS, d);
    chk(d, dev_exp(1'b0, 1'b0, 8'h00, 2'h0));
    rd_reg(8'hB8, d);
    chk(d, 32'h0000_0000);
  endtask

  task automatic t_power_limit;
    logic [31:0] d;
    spl_pair(8'hA5, 2'h3, 8'h5A, 2'h2);
    rd_reg(PCR_DEV_CAP_OFS, d);
    chk(d, dev_exp(1'b0, 1'b0, 8'h5A, 2'h2));
    spl_pair(8'hFF, 2'h1, 8'hFF, 2'h1);
    wr_reg(PCR_DEV_CAP_OFS, 32'h0000_0000);
    rd_reg(PCR_DEV_CAP_OFS, d);
    chk(d, dev_exp(1'b0, 1'b0, 8'hFF, 2'h1));
    // single message, read strobed in the very next cycle
    @(posedge sys_clk);
    spl_v <= 1'b1;
    spl_val <= 8'h3C;
    spl_scl <= 2'h1;
    @(posedge sys_clk);
    spl_v <= 1'b0;
    addr <= PCR_DEV_CAP_OFS;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
    chk(d, dev_exp(1'b0, 1'b0, 8'h3C, 2'h1));
  endtask

  // hot-plug forward; later strap changes must not leak through
  task automatic t_hotplug_forward;
    logic [31:0] d;
    do_reset(1'b0, 1'b1);
    @(posedge sys_clk);
    rev <= 1'b1;
    hp <= 1'b0;
    rd_reg(PCR_DEV_CAP_OFS, d);
    chk(d, dev_exp(1'b1, 1'b0, 8'h00, 2'h0));
    rd_reg(PCR_CAP_HDR_OFS, d);
    chk(d, hdr_exp(1'b0));
  endtask

  task automatic t_reverse;
    logic [31:0] d;
    do_reset(1'b1, 1'b1);
    rd_reg(PCR_CAP_HDR_OFS, d);
    chk(d, hdr_exp(1'b1));
    rd_reg(PCR_DEV_CAP_OFS, d);
    chk(d, dev_exp(1'b1, 1'b1, 8'h00, 2'h0));
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    t_fixed_forward();
    t_writes_ignored();
    t_power_limit();
    t_hotplug_forward();
    t_reverse();
    summarize();
  end
endmodule
